// >>> shared/rtc_irq_pkg.sv
/*
  Constants for the alarm and time-update interrupt block of the real time clock:
  register offsets, bit positions, reset values and timing counts.
  Assumes a 250 MHz block clock; nothing else is needed from outside.
*/
package rtc_irq_pkg;

  // ==========================================================================
  // clock
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_PS = 4000; // 250 MHz

  // ==========================================================================
  // register offsets (byte addresses on the register port)
  // ==========================================================================
  localparam logic [7:0] OFS_MIN_ALARM = 8'h18; // minute_alarm_setting
  localparam logic [7:0] OFS_HOUR_ALARM = 8'h19; // hour_alarm_setting
  localparam logic [7:0] OFS_DAY_ALARM = 8'h1A; // weekday_or_date_alarm_setting
  localparam logic [7:0] OFS_EXTENSION = 8'h1D; // extension_settings
  localparam logic [7:0] OFS_FLAGS = 8'h1E; // event_flags
  localparam logic [7:0] OFS_CONTROL = 8'h1F; // interrupt_and_run_control

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned BIT_COMPARE_DISABLE = 7; // in each alarm setting
  localparam int unsigned BIT_UPDATE_PERIOD_SEL = 5; // extension register
  localparam int unsigned BIT_WEEKDAY_OR_DATE = 3; // extension register
  localparam int unsigned BIT_UPDATE_FLAG = 5; // flag register
  localparam int unsigned BIT_ALARM_FLAG = 3; // flag register
  localparam int unsigned BIT_HALT = 6; // control register
  localparam int unsigned BIT_UPDATE_GATE = 5; // control register
  localparam int unsigned BIT_ALARM_GATE = 3; // control register

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] RST_ALARM_SETTING = 8'h00;
  localparam logic [7:0] RST_EXTENSION = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // ==========================================================================
  // timing
  // ==========================================================================
  // longest time from alarm match to flag and pin change
  localparam longint unsigned ALARM_LATENCY_PS = 64'd1460000000; // 1.46 ms
  localparam longint unsigned ALARM_LATENCY_CYC = ALARM_LATENCY_PS / CLK_PERIOD_PS;
  // time after an update event at which the pin is let go (rounded down)
  localparam longint unsigned UPD_RELEASE_PS = 64'd7813000000; // 7.813 ms
  localparam int unsigned UPD_RELEASE_CYC = int'(UPD_RELEASE_PS / CLK_PERIOD_PS);
  localparam int unsigned UPD_CNT_W = 21; // enough for 1953250

endpackage : rtc_irq_pkg

// >>> logic/rtc_alarm_update_irq.sv
/*
  Alarm and time-update interrupt logic of a real time clock, with its six
  registers on a plain single-cycle register port and an open-drain interrupt pin.
  Assumes the timekeeping logic on the same clock gives one-cycle second and
  minute ticks and presents the new time from the cycle after each tick on.
*/
`timescale 1ns/1ps
module rtc_alarm_update_irq #(
  parameter int unsigned UPD_RELEASE_CYCLES = rtc_irq_pkg::UPD_RELEASE_CYC,
  parameter int unsigned UPD_CNT_W = rtc_irq_pkg::UPD_CNT_W
) (
  input wire logic clk, // block clock, 250 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable, state frozen while low
  input wire logic [7:0] regAddr, // register byte address
  input wire logic [7:0] regWdata, // write data
  input wire logic regWrite, // write strobe, one cycle
  input wire logic regRead, // read strobe, one cycle
  input wire logic secondTick, // seconds counter advanced
  input wire logic minuteTick, // minutes counter advanced
  input wire logic [6:0] curMinute, // current minute, BCD
  input wire logic [5:0] curHour, // current hour, BCD
  input wire logic [5:0] curDate, // current day of month, BCD
  input wire logic [6:0] curWeekday, // current weekday, one-hot, bit 0 Sunday
  output logic [7:0] regRdata, // read data, valid the cycle after regRead
  output logic irqPinOut, // pin output level, always low
  output logic irqPinOe // high while the pin is pulled low
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  if (UPD_RELEASE_CYCLES < 1 || UPD_RELEASE_CYCLES >= (64'd1 << UPD_CNT_W)) begin : g_chk_cnt
    $error("update release count does not fit its counter");
  end
  if (rtc_irq_pkg::ALARM_LATENCY_CYC < 2) begin : g_chk_lat
    $error("alarm path needs two cycles of allowed latency");
  end

  // ==========================================================================
  // helpers
  // ==========================================================================
  // a field matches when its compare is disabled or its BCD value agrees
  function automatic logic fieldMatch(input logic disable_, input logic [6:0] setv,
                                      input logic [6:0] curv);
    fieldMatch = disable_ || (setv == curv);
  endfunction : fieldMatch

  // ==========================================================================
  // register storage
  // ==========================================================================
  logic [7:0] minAlarm_q; // minute_alarm_setting
  logic [7:0] hourAlarm_q; // hour_alarm_setting
  logic [7:0] dayAlarm_q; // weekday_or_date_alarm_setting
  logic [7:0] extension_q; // extension_settings
  logic [7:0] control_q; // interrupt_and_run_control
  logic alarmFlag_q; // alarm_event_flag
  logic updateFlag_q; // update_event_flag
  logic [7:0] rdata_q; // read data register
  logic pinLow_q; // drive-low enable of the pin
  logic pinOut_q; // pin level, held low
  logic minuteSeen_q; // minute tick one cycle late, counters now settled
  logic [UPD_CNT_W-1:0] updCnt_q; // cycles left of the update low level

  // decoded write strobes
  logic wrFlags;
  logic wrControl;
  assign wrFlags = ce && regWrite && (regAddr == rtc_irq_pkg::OFS_FLAGS);
  assign wrControl = ce && regWrite && (regAddr == rtc_irq_pkg::OFS_CONTROL);

  // control fields
  logic haltBit; // clock halt
  logic alarmGate; // alarm_irq_gate
  logic updateGate; // update_irq_gate
  logic periodSel; // update_period_select
  logic dayModeSel; // weekday_or_date_select
  assign haltBit = control_q[rtc_irq_pkg::BIT_HALT];
  assign alarmGate = control_q[rtc_irq_pkg::BIT_ALARM_GATE];
  assign updateGate = control_q[rtc_irq_pkg::BIT_UPDATE_GATE];
  assign periodSel = extension_q[rtc_irq_pkg::BIT_UPDATE_PERIOD_SEL];
  assign dayModeSel = extension_q[rtc_irq_pkg::BIT_WEEKDAY_OR_DATE];

  // plain read-write registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      minAlarm_q <= rtc_irq_pkg::RST_ALARM_SETTING;
      hourAlarm_q <= rtc_irq_pkg::RST_ALARM_SETTING;
      dayAlarm_q <= rtc_irq_pkg::RST_ALARM_SETTING;
      extension_q <= rtc_irq_pkg::RST_EXTENSION;
      control_q <= rtc_irq_pkg::RST_CONTROL;
    end else if (ce && regWrite) begin
      // each register takes the whole byte; the compare still sees it
      unique case (regAddr)
        rtc_irq_pkg::OFS_MIN_ALARM: minAlarm_q <= regWdata;
        rtc_irq_pkg::OFS_HOUR_ALARM: hourAlarm_q <= regWdata;
        rtc_irq_pkg::OFS_DAY_ALARM: dayAlarm_q <= regWdata;
        rtc_irq_pkg::OFS_EXTENSION: extension_q <= regWdata;
        rtc_irq_pkg::OFS_CONTROL: control_q <= regWdata;
        default: ; // other addresses store nothing
      endcase
    end
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= rtc_irq_pkg::RST_READ_DATA;
    end else if (ce && regRead) begin
      unique case (regAddr)
        rtc_irq_pkg::OFS_MIN_ALARM: rdata_q <= minAlarm_q;
        rtc_irq_pkg::OFS_HOUR_ALARM: rdata_q <= hourAlarm_q;
        rtc_irq_pkg::OFS_DAY_ALARM: rdata_q <= dayAlarm_q;
        rtc_irq_pkg::OFS_EXTENSION: rdata_q <= extension_q;
        rtc_irq_pkg::OFS_CONTROL: rdata_q <= control_q;
        rtc_irq_pkg::OFS_FLAGS: begin
          // flags show their state, the other bits read zero
          rdata_q <= 8'h00;
          rdata_q[rtc_irq_pkg::BIT_UPDATE_FLAG] <= updateFlag_q;
          rdata_q[rtc_irq_pkg::BIT_ALARM_FLAG] <= alarmFlag_q;
        end
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // alarm compare
  // ==========================================================================
  logic minMatch;
  logic hourMatch;
  logic dayMatch;
  logic alarmEvt; // one-cycle alarm event
  // minute BCD in bits 6..0, hour BCD in bits 5..0
  assign minMatch = fieldMatch(minAlarm_q[rtc_irq_pkg::BIT_COMPARE_DISABLE],
                               minAlarm_q[6:0], curMinute);
  assign hourMatch = fieldMatch(hourAlarm_q[rtc_irq_pkg::BIT_COMPARE_DISABLE],
                                {1'b0, hourAlarm_q[5:0]}, {1'b0, curHour});
  // weekday mask (bit 6 Saturday .. bit 0 Sunday) or BCD date
  always_comb begin
    if (dayModeSel) begin
      dayMatch = fieldMatch(dayAlarm_q[rtc_irq_pkg::BIT_COMPARE_DISABLE],
                            {1'b0, dayAlarm_q[5:0]}, {1'b0, curDate});
    end else begin
      dayMatch = dayAlarm_q[rtc_irq_pkg::BIT_COMPARE_DISABLE] ||
                 (|(dayAlarm_q[6:0] & curWeekday));
    end
  end

  // the counters settle the cycle after the minute tick; checking only then
  // means a setting equal to the present time waits for the next advance
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      minuteSeen_q <= 1'b0;
    end else if (ce) begin
      minuteSeen_q <= minuteTick;
    end
  end

  // all three disabled leaves every minute a match halt blocks
  assign alarmEvt = ce && minuteSeen_q && !haltBit &&
                    minMatch && hourMatch && dayMatch;

  // alarm flag: set wins over a clearing write, writing one does nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alarmFlag_q <= 1'b0;
    end else if (alarmEvt) begin
      alarmFlag_q <= 1'b1;
    end else if (wrFlags && !regWdata[rtc_irq_pkg::BIT_ALARM_FLAG]) begin
      alarmFlag_q <= 1'b0;
    end
  end

  // ==========================================================================
  // time update
  // ==========================================================================
  logic updateEvt; // one-cycle update event
  // second or minute boundary by the select bit, none while halted
  assign updateEvt = ce && !haltBit && (periodSel ? minuteTick : secondTick);

  // update flag: set wins over a clearing write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      updateFlag_q <= 1'b0;
    end else if (updateEvt) begin
      updateFlag_q <= 1'b1;
    end else if (wrFlags && !regWdata[rtc_irq_pkg::BIT_UPDATE_FLAG]) begin
      updateFlag_q <= 1'b0;
    end
  end

  // low-level timer: loaded on the event, the request ends when it runs out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      updCnt_q <= '0;
    end else if (updateEvt) begin
      updCnt_q <= UPD_CNT_W'(UPD_RELEASE_CYCLES);
    end else if (ce && wrFlags && !regWdata[rtc_irq_pkg::BIT_UPDATE_FLAG]) begin
      updCnt_q <= '0; // clearing the flag cancels the low level
    end else if (ce && updCnt_q != '0) begin
      updCnt_q <= updCnt_q - UPD_CNT_W'(1);
    end
  end

  // ==========================================================================
  // interrupt pin
  // ==========================================================================
  logic alarmReq;
  logic updateReq;
  logic pinReq;
  assign alarmReq = alarmFlag_q && alarmGate; // held until cleared
  assign updateReq = updCnt_q != '0 && updateGate;
  assign pinReq = alarmReq || updateReq;

  // open-drain: enable pulls low, otherwise released
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinLow_q <= 1'b0;
      pinOut_q <= 1'b0;
    end else if (ce) begin
      pinLow_q <= pinReq;
      pinOut_q <= 1'b0;
    end
  end

  assign regRdata = rdata_q;
  assign irqPinOe = pinLow_q;
  assign irqPinOut = pinOut_q;

  // ==========================================================================
  // assertions
  // ==========================================================================
  sequence s_alarmHit;
    alarmEvt;
  endsequence
  sequence s_alarmShown;
    alarmFlag_q ##1 (irqPinOe || !$past(ce) || !$past(alarmGate));
  endsequence

  property p_alarmSetsFlag;
    @(posedge clk) disable iff (!rst_n) s_alarmHit |=> s_alarmShown;
  endproperty
  a_alarmSetsFlag: assert property (p_alarmSetsFlag)
    else $error("alarm event did not set flag and pin");

  property p_alarmHeld;
    @(posedge clk) disable iff (!rst_n)
      alarmFlag_q && !(wrFlags && !regWdata[rtc_irq_pkg::BIT_ALARM_FLAG]) |=> alarmFlag_q;
  endproperty
  a_alarmHeld: assert property (p_alarmHeld)
    else $error("alarm flag dropped without a clearing write");

  property p_alarmClear;
    @(posedge clk) disable iff (!rst_n)
      wrFlags && !regWdata[rtc_irq_pkg::BIT_ALARM_FLAG] && !alarmEvt
      |=> !alarmFlag_q ##1 (!irqPinOe || $past(updateReq) || !$past(ce));
  endproperty
  a_alarmClear: assert property (p_alarmClear)
    else $error("clearing write did not clear alarm flag and pin");

  property p_haltBlocks;
    @(posedge clk) disable iff (!rst_n) haltBit |=> !$rose(alarmFlag_q) && !$rose(updateFlag_q);
  endproperty
  a_haltBlocks: assert property (p_haltBlocks)
    else $error("event raised while halted");

  property p_everyMinute;
    @(posedge clk) disable iff (!rst_n)
      ce && minuteSeen_q && !haltBit && minAlarm_q[rtc_irq_pkg::BIT_COMPARE_DISABLE] &&
      hourAlarm_q[rtc_irq_pkg::BIT_COMPARE_DISABLE] &&
      dayAlarm_q[rtc_irq_pkg::BIT_COMPARE_DISABLE]
      |=> alarmFlag_q;
  endproperty
  a_everyMinute: assert property (p_everyMinute)
    else $error("all compares disabled but no alarm this minute");

  property p_onlyOnAdvance;
    @(posedge clk) disable iff (!rst_n) alarmEvt |-> $past(minuteTick) || !$past(ce);
  endproperty
  a_onlyOnAdvance: assert property (p_onlyOnAdvance)
    else $error("alarm raised without a minute advance");

  property p_periodSelect;
    @(posedge clk) disable iff (!rst_n)
      periodSel && !minuteTick |=> !$rose(updateFlag_q);
  endproperty
  a_periodSelect: assert property (p_periodSelect)
    else $error("update event off the minute boundary");

  property p_updateRelease;
    @(posedge clk) disable iff (!rst_n)
      updateEvt |=> updCnt_q == UPD_CNT_W'(UPD_RELEASE_CYCLES) && updateFlag_q;
  endproperty
  a_updateRelease: assert property (p_updateRelease)
    else $error("update event did not load release timer or set flag");

  property p_pinFollows;
    @(posedge clk) disable iff (!rst_n)
      ce |=> irqPinOe == $past(pinReq);
  endproperty
  a_pinFollows: assert property (p_pinFollows)
    else $error("pin drive does not follow gated requests");

  property p_gateOnlyPin;
    @(posedge clk) disable iff (!rst_n)
      !alarmGate && !updateGate && ce |=> !irqPinOe;
  endproperty
  a_gateOnlyPin: assert property (p_gateOnlyPin)
    else $error("pin driven with both gates closed");

  // update event: release timer loaded, then the pin pulled low if gated in
  sequence s_updateLoaded;
    updCnt_q != '0;
  endsequence

  property p_updateDrives;
    @(posedge clk) disable iff (!rst_n)
      updateEvt |=> s_updateLoaded ##1 (irqPinOe || !$past(ce) || !$past(updateGate));
  endproperty
  a_updateDrives: assert property (p_updateDrives)
    else $error("update event did not pull the pin low");

endmodule : rtc_alarm_update_irq

// >>> sim/irq_host_model.sv
/*
  Host processor model for the alarm and time-update interrupt block:
  register port tasks and the pulled-up interrupt line it watches.
  Assumes the block samples the register port on rising clk edges.
*/
`timescale 1ns/1ps
module irq_host_model (
  input wire logic clk, // block clock
  output logic [7:0] regAddr, // register byte address
  output logic [7:0] regWdata, // write data
  output logic regWrite, // write strobe
  output logic regRead, // read strobe
  input wire logic [7:0] regRdata, // read data from the block
  input wire logic irqPinOut, // pin data, low when driven
  input wire logic irqPinOe, // pin drive enable
  output logic irqLine // wire level seen by the host
);
  // ==========================================================================
  // open-drain line with board pull-up
  // ==========================================================================
  assign irqLine = irqPinOe ? irqPinOut : 1'h1;

  // quiet bus at time zero
  initial begin
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'h0;
    regRead = 1'h0;
  end

  // ==========================================================================
  // register access, launched off the falling edge
  // ==========================================================================
  // one write; data goes stale afterwards so nothing relies on it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'h1;
    @(negedge clk);
    regWrite = 1'h0;
    regWdata = ~d;
  endtask : wr

  // one read; data is registered, so it is taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regRead = 1'h1;
    @(negedge clk);
    regRead = 1'h0;
    d = regRdata;
  endtask : rd
endmodule : irq_host_model

// >>> sim/tb.sv
/*
  Self-checking testbench for the alarm and time-update interrupt block.
  Assumes the block, its package and the host model are compiled first.
*/
`timescale 1ns/1ps
module tb;
  // ==========================================================================
  // signals
  // ==========================================================================
  localparam logic [7:0] aMin = rtc_irq_pkg::OFS_MIN_ALARM; // short address names
  localparam logic [7:0] aHour = rtc_irq_pkg::OFS_HOUR_ALARM;
  localparam logic [7:0] aDay = rtc_irq_pkg::OFS_DAY_ALARM;
  localparam logic [7:0] aExt = rtc_irq_pkg::OFS_EXTENSION;
  localparam logic [7:0] aFlg = rtc_irq_pkg::OFS_FLAGS;
  localparam logic [7:0] aCtl = rtc_irq_pkg::OFS_CONTROL;
  logic clk, rstN, secondTick, minuteTick;
  logic [6:0] curMinute, curWeekday;
  logic [5:0] curHour, curDate;
  logic [7:0] regAddr, regWdata, regRdata, rdVal;
  logic regWrite, regRead, irqPinOut, irqPinOe, irqLine;
  int badCount, nChecks;

  // short release count keeps the run brief
  rtc_alarm_update_irq #(.UPD_RELEASE_CYCLES(20), .UPD_CNT_W(21)) DUT (
    .clk(clk), .rst_n(rstN), .ce(1'h1), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .secondTick(secondTick),
    .minuteTick(minuteTick), .curMinute(curMinute), .curHour(curHour), .curDate(curDate),
    .curWeekday(curWeekday), .regRdata(regRdata), .irqPinOut(irqPinOut), .irqPinOe(irqPinOe));

  irq_host_model host (
    .clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .irqPinOut(irqPinOut),
    .irqPinOe(irqPinOe), .irqLine(irqLine));

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // read a register and compare the masked bits
  task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    host.rd(a, rdVal);
    chk($sformatf("register %h", a), exp, rdVal & m);
  endtask : rdChk

  // settle one cycle, then compare the line level
  task automatic pinChk(input logic exp);
    @(negedge clk);
    chk("irq line", {7'h00, exp}, {7'h00, irqLine});
  endtask : pinChk

  // one counter advance: tick, new time from the next cycle, event settles
  task automatic adv(input logic isMin, input logic [6:0] m, input logic [5:0] h,
                     input logic [5:0] d, input logic [6:0] wd);
    @(negedge clk);
    minuteTick = isMin;
    secondTick = ~isMin;
    @(negedge clk);
    minuteTick = 1'h0;
    secondTick = 1'h0;
    curMinute = m;
    curHour = h;
    curDate = d;
    curWeekday = wd;
    repeat (3) @(negedge clk);
  endtask : adv

  // ==========================================================================
  // scenarios
  // ==========================================================================
  // reset values, storage use, unmapped place
  task automatic testRegs();
    logic [7:0] offs [6];
    offs = '{aMin, aHour, aDay, aExt, aFlg, aCtl};
    foreach (offs[i]) rdChk(offs[i], 8'hFF, 8'h00);
    for (int i = 0; i < 3; i++) host.wr(offs[i], 8'h5A);
    for (int i = 0; i < 3; i++) rdChk(offs[i], 8'hFF, 8'h5A);
    host.wr(8'h1B, 8'hFF);
    rdChk(8'h1B, 8'hFF, 8'h00);
    host.wr(aCtl, 8'h97);
    rdChk(aCtl, 8'hFF, 8'h97);
    host.wr(aCtl, 8'h00);
  endtask : testRegs

  // minute alarm: fire, hold, gate, clear, halt, equal-to-now
  task automatic testAlarm();
    host.wr(aMin, 8'h30);
    host.wr(aHour, 8'h80);
    host.wr(aDay, 8'h80);
    host.wr(aCtl, 8'h08);
    host.wr(aFlg, 8'h00);
    adv(1'h1, 7'h29, 6'h00, 6'h01, 7'h01);
    rdChk(aFlg, 8'h08, 8'h00);
    adv(1'h1, 7'h30, 6'h00, 6'h01, 7'h01);
    pinChk(1'h0);
    rdChk(aFlg, 8'h08, 8'h08);
    repeat (50) @(negedge clk);
    pinChk(1'h0);
    host.wr(aFlg, 8'h08);
    rdChk(aFlg, 8'h08, 8'h08);
    host.wr(aCtl, 8'h00);
    pinChk(1'h1);
    rdChk(aFlg, 8'h08, 8'h08);
    host.wr(aCtl, 8'h08);
    pinChk(1'h0);
    host.wr(aFlg, 8'h00);
    pinChk(1'h1);
    rdChk(aFlg, 8'h08, 8'h00);
    host.wr(aMin, 8'h30);
    repeat (10) @(negedge clk);
    rdChk(aFlg, 8'h08, 8'h00);
    host.wr(aCtl, 8'h48);
    adv(1'h1, 7'h31, 6'h00, 6'h01, 7'h01);
    adv(1'h1, 7'h30, 6'h00, 6'h01, 7'h01);
    rdChk(aFlg, 8'h08, 8'h00);
    host.wr(aCtl, 8'h00);
    adv(1'h1, 7'h31, 6'h00, 6'h01, 7'h01);
    adv(1'h1, 7'h30, 6'h00, 6'h01, 7'h01);
    pinChk(1'h1);
    rdChk(aFlg, 8'h08, 8'h08);
    host.wr(aFlg, 8'h00);
  endtask : testAlarm

  // weekday mask, date, hour and every-minute matching
  task automatic testFields();
    host.wr(aCtl, 8'h08);
    host.wr(aMin, 8'h80);
    host.wr(aHour, 8'h80);
    host.wr(aDay, 8'h41);
    adv(1'h1, 7'h01, 6'h00, 6'h01, 7'h02);
    rdChk(aFlg, 8'h08, 8'h00);
    adv(1'h1, 7'h02, 6'h00, 6'h01, 7'h40);
    rdChk(aFlg, 8'h08, 8'h08);
    host.wr(aFlg, 8'h00);
    host.wr(aExt, 8'h08);
    host.wr(aDay, 8'h15);
    adv(1'h1, 7'h03, 6'h00, 6'h14, 7'h40);
    rdChk(aFlg, 8'h08, 8'h00);
    adv(1'h1, 7'h04, 6'h00, 6'h15, 7'h40);
    rdChk(aFlg, 8'h08, 8'h08);
    host.wr(aFlg, 8'h00);
    host.wr(aDay, 8'h80);
    host.wr(aHour, 8'h18);
    adv(1'h1, 7'h05, 6'h17, 6'h15, 7'h40);
    rdChk(aFlg, 8'h08, 8'h00);
    adv(1'h1, 7'h06, 6'h18, 6'h15, 7'h40);
    rdChk(aFlg, 8'h08, 8'h08);
    host.wr(aHour, 8'h80);
    for (int i = 0; i < 3; i++) begin
      host.wr(aFlg, 8'h00);
      repeat (5) @(negedge clk);
      rdChk(aFlg, 8'h08, 8'h00);
      adv(1'h1, 7'h07 + 7'(i), 6'h18, 6'h15, 7'h40);
      rdChk(aFlg, 8'h08, 8'h08);
    end
    host.wr(aCtl, 8'h00);
    host.wr(aExt, 8'h00);
    host.wr(aFlg, 8'h00);
  endtask : testFields

  // update events: rate, release time, clearing, gate, halt
  task automatic testUpdate();
    host.wr(aCtl, 8'h20);
    adv(1'h0, 7'h10, 6'h18, 6'h15, 7'h40);
    pinChk(1'h0);
    rdChk(aFlg, 8'h20, 8'h20);
    // release count 20: last low cycle, then the first released one
    repeat (13) @(negedge clk);
    pinChk(1'h0);
    pinChk(1'h1);
    rdChk(aFlg, 8'h20, 8'h20);
    host.wr(aFlg, 8'h00);
    adv(1'h0, 7'h10, 6'h18, 6'h15, 7'h40);
    host.wr(aFlg, 8'h08);
    pinChk(1'h1);
    rdChk(aFlg, 8'h20, 8'h00);
    host.wr(aExt, 8'h20);
    adv(1'h0, 7'h10, 6'h18, 6'h15, 7'h40);
    rdChk(aFlg, 8'h20, 8'h00);
    adv(1'h1, 7'h11, 6'h18, 6'h15, 7'h40);
    pinChk(1'h0);
    host.wr(aFlg, 8'h00);
    host.wr(aExt, 8'h00);
    host.wr(aCtl, 8'h00);
    adv(1'h0, 7'h11, 6'h18, 6'h15, 7'h40);
    pinChk(1'h1);
    rdChk(aFlg, 8'h20, 8'h20);
    host.wr(aFlg, 8'h00);
    host.wr(aCtl, 8'h60);
    adv(1'h0, 7'h11, 6'h18, 6'h15, 7'h40);
    rdChk(aFlg, 8'h20, 8'h00);
  endtask : testUpdate

  // ==========================================================================
  // verdict, clock, watchdog, main sequence
  // ==========================================================================
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : endOfTest

  // 250 MHz clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // cut a hang well past the expected four hundred or so cycles
  initial begin
    #80000;
    badCount++;
    endOfTest();
  end

  // reset, then every scenario in turn
  initial begin
    badCount = 0;
    nChecks = 0;
    rstN = 1'h0;
    secondTick = 1'h0;
    minuteTick = 1'h0;
    curMinute = 7'h00;
    curHour = 6'h00;
    curDate = 6'h01;
    curWeekday = 7'h01;
    repeat (20) @(negedge clk);
    rstN = 1'h1;
    testRegs();
    testAlarm();
    testFields();
    testUpdate();
    endOfTest();
  end
endmodule : tb
